// *** src/gpf_pkg.sv ***
package gpf_pkg;
  localparam int GPF_PINS = 8;
  localparam int GPF_AW = 4;
  localparam int GPF_DW = 16;
  // Register offsets
  localparam logic [3:0] GPF_OFS_VALUE = 4'h0;
  localparam logic [3:0] GPF_OFS_DIR = 4'h1;
  localparam logic [3:0] GPF_OFS_PULL = 4'h2;
  localparam logic [3:0] GPF_OFS_FLAG = 4'h3;
  localparam logic [3:0] GPF_OFS_EVCTL = 4'h4;
  localparam logic [3:0] GPF_OFS_DEB = 4'h5;
  localparam logic [3:0] GPF_OFS_MODE = 4'h6;
  localparam logic [3:0] GPF_OFS_KEYCFG = 4'h7;
  localparam logic [3:0] GPF_OFS_GROUP = 4'h8;
  localparam int GPF_HI_LSB = 8;
  localparam logic [7:0] GPF_RST_BYTE = 8'h00;
  localparam logic [7:0] GPF_RST_MODE = 8'h00;
  localparam logic [1:0] GPF_RST_KEY = 2'h0;
  // Three ticks: the first may land at once, so 2 to 3 periods
  localparam int GPF_DEB_TICKS = 3;
  localparam logic [1:0] GPF_KEY_OFF = 2'h0;
  localparam logic [1:0] GPF_KEY_P01 = 2'h1;
  localparam logic [1:0] GPF_KEY_P012 = 2'h2;
  localparam logic [1:0] GPF_KEY_P0123 = 2'h3;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } gpf_bus_t;

  typedef struct packed {
    logic [7:0] drive_out;
    logic [7:0] drive_oe;
    logic [7:0] pull_up_on;
    logic [7:0] pull_down_on;
  } gpf_pad_t;

  typedef enum logic [1:0] {
    GPF_DB_IDLE,
    GPF_DB_COUNT
  } gpf_db_state_t;
endpackage

// *** src/gpf_clkdiv.sv ***
`timescale 1ns/10ps
module gpf_clkdiv #(
  parameter int DIV = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  output logic tick
);
  import gpf_pkg::*;
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } gpf_div_st_t;
  gpf_div_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= 16'(DIV - 1)) begin
      s_d.cnt = 16'h0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// *** src/gpf_debounce.sv ***
`timescale 1ns/10ps
module gpf_debounce (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic tick,
  input wire logic din,
  output logic dout
);
  import gpf_pkg::*;
  typedef struct packed {
    gpf_db_state_t st;
    logic [1:0] cnt;
    logic out;
  } gpf_db_st_t;
  gpf_db_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      GPF_DB_IDLE: begin
        if (din != s_q.out) begin
          s_d.st = GPF_DB_COUNT;
          s_d.cnt = 2'h0;
        end
      end
      GPF_DB_COUNT: begin
        if (din == s_q.out) begin
          s_d.st = GPF_DB_IDLE;
        end else if (tick) begin
          if (s_q.cnt == 2'(GPF_DEB_TICKS - 1)) begin
            s_d.out = din;
            s_d.st = GPF_DB_IDLE;
          end else begin
            s_d.cnt = s_q.cnt + 2'h1;
          end
        end
      end
      default: s_d.st = GPF_DB_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.out;
endmodule

// *** src/gpf_port.sv ***
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module gpf_port #(
  parameter logic [7:0] GPIO_MASK = 8'hFF,
  parameter logic [7:0] EVENT_MASK = 8'hFF,
  parameter logic [7:0] FILTER_MASK = 8'hFF,
  parameter int FILTER_DIV = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input gpf_pkg::gpf_bus_t bus,
  output logic [15:0] rdata,
  input wire logic [7:0] pin_in,
  output gpf_pkg::gpf_pad_t pad,
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_oe,
  output logic [7:0] periph_in,
  input wire logic debounce_clock_stopped,
  output logic event_irq,
  output logic key_reset_req
);
  import gpf_pkg::*;

  typedef struct packed {
    logic [7:0] pin_drive_value;
    logic [7:0] pin_input_enable;
    logic [7:0] pin_output_enable;
    logic [7:0] pull_direction_select;
    logic [7:0] pull_resistor_enable;
    logic [7:0] pin_event_flag;
    logic [7:0] trigger_edge_select;
    logic [7:0] pin_event_enable;
    logic [7:0] debounce_enable;
    logic [7:0] peripheral_function_select;
    logic [1:0] key_reset_combination;
    logic [7:0] pin_sampled_value;
    logic [7:0] edge_prev;
    logic [15:0] rdata;
    gpf_pad_t pad;
    logic [7:0] periph_in;
    logic event_irq;
    logic key_reset_req;
  } gpf_state_t;

  gpf_state_t s_q, s_d;
  logic tick;
  logic [7:0] filt;
  logic [7:0] eff_in;
  logic [7:0] key_mask;

  function automatic logic [7:0] gpf_hi(input logic [15:0] w);
    gpf_hi = w[15:GPF_HI_LSB];
  endfunction

  function automatic logic [7:0] gpf_lo(input logic [15:0] w);
    gpf_lo = w[7:0];
  endfunction

  function automatic logic gpf_hit(input gpf_bus_t b, input logic [3:0] o);
    gpf_hit = b.wr && (b.addr == o);
  endfunction

  gpf_clkdiv #(
    .DIV(FILTER_DIV)
  ) u_div (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .tick(tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < GPF_PINS; gi++) begin : g_filt
      gpf_debounce u_db (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .tick(tick),
        .din(pin_in[gi]),
        .dout(filt[gi])
      );
    end
  endgenerate

  always_comb begin
    eff_in = pin_in;
    for (int i = 0; i < GPF_PINS; i++) begin
      if (FILTER_MASK[i] && s_q.debounce_enable[i] &&
          !debounce_clock_stopped) begin
        eff_in[i] = filt[i];
      end
    end
    case (s_q.key_reset_combination)
      GPF_KEY_P01: key_mask = 8'h03;
      GPF_KEY_P012: key_mask = 8'h07;
      GPF_KEY_P0123: key_mask = 8'h0F;
      default: key_mask = 8'h00;
    endcase
  end

  always_comb begin
    logic [7:0] gmode;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] hit;
    logic [7:0] clr;
    gmode = '0;
    rise = '0;
    fall = '0;
    hit = '0;
    clr = '0;
    s_d = s_q;
    gmode = ~s_q.peripheral_function_select & GPIO_MASK;

    // Register writes
    if (gpf_hit(bus, GPF_OFS_VALUE)) begin
      s_d.pin_drive_value = gpf_hi(bus.wdata);
    end
    if (gpf_hit(bus, GPF_OFS_DIR)) begin
      s_d.pin_input_enable = gpf_hi(bus.wdata);
      s_d.pin_output_enable = gpf_lo(bus.wdata);
    end
    if (gpf_hit(bus, GPF_OFS_PULL)) begin
      s_d.pull_direction_select = gpf_hi(bus.wdata);
      s_d.pull_resistor_enable = gpf_lo(bus.wdata);
    end
    if (gpf_hit(bus, GPF_OFS_EVCTL)) begin
      s_d.trigger_edge_select = gpf_hi(bus.wdata);
      s_d.pin_event_enable = gpf_lo(bus.wdata);
    end
    if (gpf_hit(bus, GPF_OFS_DEB)) begin
      s_d.debounce_enable = gpf_lo(bus.wdata) & FILTER_MASK;
    end
    if (gpf_hit(bus, GPF_OFS_MODE)) begin
      s_d.peripheral_function_select = gpf_lo(bus.wdata);
    end
    if (gpf_hit(bus, GPF_OFS_KEYCFG)) begin
      s_d.key_reset_combination = bus.wdata[1:0];
    end
    if (gpf_hit(bus, GPF_OFS_FLAG)) begin
      clr = gpf_lo(bus.wdata);
    end

    // non-GPIO pins held at reset state
    s_d.pin_drive_value &= GPIO_MASK;
    s_d.pin_input_enable &= GPIO_MASK;
    s_d.pin_output_enable &= GPIO_MASK;
    s_d.pull_direction_select &= GPIO_MASK;
    s_d.pull_resistor_enable &= GPIO_MASK;
    s_d.trigger_edge_select &= GPIO_MASK & EVENT_MASK;
    s_d.pin_event_enable &= GPIO_MASK & EVENT_MASK;

    // value seen one clock before read
    s_d.pin_sampled_value = pin_in & s_q.pin_input_enable & gmode;

    rise = eff_in & ~s_q.edge_prev;
    fall = ~eff_in & s_q.edge_prev;
    hit = (s_q.trigger_edge_select & fall) |
      (~s_q.trigger_edge_select & rise);
    s_d.edge_prev = eff_in;
    hit &= EVENT_MASK & gmode & s_q.pin_input_enable;
    s_d.pin_event_flag = (s_q.pin_event_flag & ~clr) | hit;

    s_d.event_irq = |(s_d.pin_event_flag & s_d.pin_event_enable);

    s_d.key_reset_req = (key_mask != 8'h00) &&
      ((eff_in & key_mask) == 8'h00);

    // Pad drive
    for (int i = 0; i < GPF_PINS; i++) begin
      if (s_q.peripheral_function_select[i] || !GPIO_MASK[i]) begin
        s_d.pad.drive_out[i] = periph_out[i];
        s_d.pad.drive_oe[i] = periph_oe[i] & s_q.peripheral_function_select[i];
        s_d.pad.pull_up_on[i] = 1'b0;
        s_d.pad.pull_down_on[i] = 1'b0;
      end else begin
        s_d.pad.drive_out[i] = s_q.pin_drive_value[i];
        s_d.pad.drive_oe[i] = s_q.pin_output_enable[i];
        s_d.pad.pull_up_on[i] = !s_q.pin_output_enable[i] &&
          s_q.pull_resistor_enable[i] && s_q.pull_direction_select[i];
        s_d.pad.pull_down_on[i] = !s_q.pin_output_enable[i] &&
          s_q.pull_resistor_enable[i] && !s_q.pull_direction_select[i];
      end
    end
    s_d.periph_in = pin_in & s_q.peripheral_function_select;

    // Read data one cycle after strobe
    s_d.rdata = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        GPF_OFS_VALUE: s_d.rdata = {s_q.pin_drive_value,
          s_q.pin_sampled_value};
        GPF_OFS_DIR: s_d.rdata = {s_q.pin_input_enable,
          s_q.pin_output_enable};
        GPF_OFS_PULL: s_d.rdata = {s_q.pull_direction_select,
          s_q.pull_resistor_enable};
        GPF_OFS_FLAG: s_d.rdata = {8'h00, s_q.pin_event_flag};
        GPF_OFS_EVCTL: s_d.rdata = {s_q.trigger_edge_select,
          s_q.pin_event_enable};
        GPF_OFS_DEB: s_d.rdata = {8'h00, s_q.debounce_enable};
        GPF_OFS_MODE: s_d.rdata = {8'h00, s_q.peripheral_function_select};
        GPF_OFS_KEYCFG: s_d.rdata = {14'h0000, s_q.key_reset_combination};
        GPF_OFS_GROUP: s_d.rdata = {15'h0000, s_q.event_irq};
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign pad = s_q.pad;
  assign periph_in = s_q.periph_in;
  assign event_irq = s_q.event_irq;
  assign key_reset_req = s_q.key_reset_req;
endmodule

// *** sim/gpf_port_assertions.sv ***
`timescale 1ns/10ps
module gpf_port_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input gpf_pkg::gpf_bus_t bus,
  input wire logic [15:0] rdata,
  input wire logic [7:0] pin_in,
  input gpf_pkg::gpf_pad_t pad,
  input wire logic [7:0] periph_oe,
  input wire logic [7:0] periph_in,
  input wire logic event_irq,
  input wire logic key_reset_req
);
  import gpf_pkg::*;
  logic [7:0] mode_q;
  // Shadow of the mode byte, seen from the bus
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_q <= 8'h00;
    end else if (bus.wr && bus.addr == GPF_OFS_MODE) begin
      mode_q <= bus.wdata[7:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  reset_out_a: assert property ($rose(nrst) |->
    pad == '0 && !event_irq && !key_reset_req)
    else $error("outputs not clear after reset");
  pull_excl_a: assert property (
    (pad.pull_up_on & pad.pull_down_on) == 8'h00)
    else $error("pull up and down together");
  oe_write_a: assert property (bus.wr && bus.addr == GPF_OFS_DIR |->
    ##2 (pad.drive_oe & ~mode_q) == ($past(bus.wdata[7:0], 2) & ~mode_q))
    else $error("output enable not from write");
  // Mode changes excluded: they may land a cycle apart
  periph_oe_a: assert property (mode_q == $past(mode_q) |->
    (pad.drive_oe & mode_q) == ($past(periph_oe) & mode_q))
    else $error("peripheral enable not passed");
  periph_in_a: assert property (mode_q == $past(mode_q) |->
    periph_in == ($past(pin_in) & mode_q))
    else $error("peripheral input wrong");
  rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
    else $error("read data outside read cycle");
  flag_hi_a: assert property (bus.rd && bus.addr == GPF_OFS_FLAG |=>
    rdata[15:8] == 8'h00)
    else $error("flag high byte not zero");
  irq_fall_a: assert property ($fell(event_irq) |->
    $past(bus.wr) || $past(bus.wr, 2))
    else $error("event request fell without write");
  key_rise_a: assert property ($rose(key_reset_req) |->
    $past(pin_in[1:0]) == 2'b00 || $past(pin_in[1:0], 2) == 2'b00)
    else $error("key reset without low pins");
endmodule
bind gpf_port gpf_port_checker u_gpf_port_checker (.clk_sys(clk_sys),
  .nrst(nrst), .bus(bus), .rdata(rdata), .pin_in(pin_in), .pad(pad),
  .periph_oe(periph_oe), .periph_in(periph_in), .event_irq(event_irq),
  .key_reset_req(key_reset_req));

// *** sim/gpf_pins_model.sv ***
`timescale 1ns/10ps
module gpf_pins_model (
  input wire logic clk_sys,
  input gpf_pkg::gpf_pad_t pad,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_drv,
  output logic [7:0] pin_in
);
  import gpf_pkg::*;
  logic [7:0] float_q = 8'h55;
  always_ff @(posedge clk_sys) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.drive_oe[i]) pin_in[i] = pad.drive_out[i];
      else if (ext_drv[i]) pin_in[i] = ext_val[i];
      else if (pad.pull_up_on[i]) pin_in[i] = 1'b1;
      else if (pad.pull_down_on[i]) pin_in[i] = 1'b0;
      else pin_in[i] = float_q[i];
    end
  end
endmodule

// *** sim/gpf_port_tb_top.sv ***
`timescale 1ns/10ps
module gpf_port_tb_top;
  import gpf_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  gpf_bus_t bus = '0;
  logic [15:0] rdata;
  logic [7:0] pin_in;
  logic [7:0] periph_in;
  gpf_pad_t pad;
  logic [7:0] periph_out = 8'h00;
  logic [7:0] periph_oe = 8'h00;
  logic debounce_clock_stopped = 1'b0;
  logic event_irq;
  logic key_reset_req;
  logic [7:0] ext_val = 8'hFF;
  logic [7:0] ext_drv = 8'h00;
  int miscompares = 0;
  int total_checks = 0;
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  gpf_port #(.FILTER_DIV(2)) u_gpf_port (.clk_sys(clk_sys), .nrst(nrst),
    .bus(bus), .rdata(rdata), .pin_in(pin_in), .pad(pad),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
    .debounce_clock_stopped(debounce_clock_stopped),
    .event_irq(event_irq), .key_reset_req(key_reset_req));
  gpf_pins_model u_gpf_pins_model (.clk_sys(clk_sys), .pad(pad),
    .ext_val(ext_val), .ext_drv(ext_drv), .pin_in(pin_in));
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  task automatic rchk(input string s, input logic [3:0] a,
    input logic [15:0] e);
    @(posedge clk_sys);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 chk(s, rdata, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pins(input logic [7:0] v);
    @(posedge clk_sys);
    ext_val <= v;
  endtask
  // Bounded wait on irq (sel 1) or key request (sel 0)
  task automatic wait_sig(input string s, input bit sel, v, input int n);
    for (int i = 0; i < n; i++) begin
      if ((sel ? event_irq : key_reset_req) === v) begin
        total_checks++;
        return;
      end
      cyc(1);
    end
    miscompares++;
    $display("ERROR %s expected %b seen timeout", s, v);
    final_report();
  endtask
  task automatic t_reset();
    for (int a = 0; a < 9; a++) begin
      rchk("reset reg", 4'(a), 16'h0000);
    end
    chk("reset pad", 16'(pad.drive_oe), 16'h0000);
    wr(4'h9, 16'hFFFF);
    rchk("unmapped", 4'h9, 16'h0000);
  endtask
  task automatic t_pins();
    wr(GPF_OFS_DIR, 16'h00FF);
    wr(GPF_OFS_VALUE, 16'hA500);
    wr(GPF_OFS_PULL, 16'h0FFF);
    cyc(2);
    chk("drive", {pad.drive_oe, pad.drive_out}, 16'hFFA5);
    chk("pull oe", {pad.pull_up_on, pad.pull_down_on}, 16'h0);
    wr(GPF_OFS_DIR, 16'hFF00);
    cyc(2);
    chk("pull", {pad.pull_up_on, pad.pull_down_on}, 16'h0FF0);
    chk("hi z", 16'(pad.drive_oe), 16'h0000);
    rchk("sampled", GPF_OFS_VALUE, 16'hA50F);
    wr(GPF_OFS_DIR, 16'h0000);
    rchk("input off", GPF_OFS_VALUE, 16'hA500);
  endtask
  task automatic t_periph();
    @(posedge clk_sys);
    periph_oe <= 8'h01;
    periph_out <= 8'h01;
    wr(GPF_OFS_DIR, 16'hFF00);
    wr(GPF_OFS_MODE, 16'h0001);
    cyc(2);
    chk("periph", {pad.drive_oe, 7'h0, pad.drive_out[0]}, 16'h0101);
    chk("periph in", 16'(periph_in), 16'h0001);
    rchk("periph read", GPF_OFS_VALUE, 16'hA50E);
    wr(GPF_OFS_MODE, 16'h0000);
    periph_oe <= 8'h00;
  endtask
  task automatic t_event();
    @(posedge clk_sys);
    ext_drv <= 8'hFF;
    cyc(4);
    wr(GPF_OFS_FLAG, 16'h00FF);
    wr(GPF_OFS_EVCTL, 16'h0101);
    pins(8'hFD);
    cyc(4);
    pins(8'hFF);
    cyc(4);
    rchk("flag rise", GPF_OFS_FLAG, 16'h0002);
    chk("irq masked", 16'(event_irq), 16'h0000);
    rchk("group masked", GPF_OFS_GROUP, 16'h0000);
    pins(8'hFE);
    wait_sig("irq set", 1'b1, 1'b1, 8);
    rchk("flag fall", GPF_OFS_FLAG, 16'h0003);
    rchk("group set", GPF_OFS_GROUP, 16'h0001);
    wr(GPF_OFS_FLAG, 16'h0000);
    rchk("flag hold", GPF_OFS_FLAG, 16'h0003);
    wr(GPF_OFS_FLAG, 16'h0001);
    wait_sig("irq clear", 1'b1, 1'b0, 8);
    pins(8'hFF);
    cyc(4);
    rchk("flag no fall", GPF_OFS_FLAG, 16'h0002);
  endtask
  task automatic t_key();
    logic seen;
    wr(GPF_OFS_KEYCFG, 16'(GPF_KEY_P01));
    pins(8'hFC);
    wait_sig("key two", 1'b0, 1'b1, 8);
    rchk("key read", GPF_OFS_VALUE, 16'hA5FC);
    pins(8'hFF);
    wait_sig("key off", 1'b0, 1'b0, 8);
    wr(GPF_OFS_KEYCFG, 16'(GPF_KEY_P0123));
    pins(8'hF8);
    cyc(8);
    chk("key partial", 16'(key_reset_req), 16'h0000);
    pins(8'hFF);
    wr(GPF_OFS_EVCTL, 16'h0000);
    wr(GPF_OFS_DEB, 16'h000F);
    cyc(12);
    seen = 1'b0;
    pins(8'hF0);
    pins(8'hF0);
    pins(8'hFF);
    repeat (12) begin
      cyc(1);
      seen = seen | key_reset_req;
    end
    chk("short low", 16'(seen), 16'h0000);
    pins(8'hF0);
    wait_sig("long low", 1'b0, 1'b1, 30);
    pins(8'hFF);
    wait_sig("long off", 1'b0, 1'b0, 30);
    @(posedge clk_sys);
    debounce_clock_stopped <= 1'b1;
    pins(8'hF0);
    wait_sig("bypass", 1'b0, 1'b1, 4);
    pins(8'hFF);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_pins();
    t_periph();
    t_event();
    t_key();
    final_report();
  end
endmodule
